/* sar_adc_map.vh */
/*
  Constants for the SAR converter control block: code values, widths,
  timing figures and derived cycle counts.
  Assumes a 100 MHz system clock and inclusion by its bare name.
*/
`ifndef SAR_ADC_MAP_VH
`define SAR_ADC_MAP_VH

`define RES_BITS 16
`define BYTE_BITS 8
`define MSB_IDX 4'hF
`define CODE_ZERO 16'h0000
`define CODE_MINUS_ONE 16'hFFFF
`define CODE_POS_MAX 16'h7FFF
`define CODE_NEG_MAX 16'h8000
`define CLK_PERIOD_NS 10
`define CONV_CLK_NS 140
`define CONV_DIV_CYCLES ((`CONV_CLK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DIV_ZERO 4'h0
`define DIV_LAST 4'hD
`define LSB_IDX 4'h0
`define PIN_SEL 0
`define PIN_RC 1
`define PIN_SWAP 2
`define PIN_COUNT 3
`define PIN_IDLE 3'h3

`endif

/* conv_clock_div.v */
/*
  Divider that makes the one-cycle conversion clock enable.
  Assumes the system clock and synchronous active-low reset; runs only while enabled.
*/
`timescale 1ns/1ns
`default_nettype none
`include "sar_adc_map.vh"
module conv_clock_div (
  // Clock and reset.
  input wire clk,
  input wire nrst,
  // Control.
  input wire run,
  output reg tick
);
  reg [3:0] count;

  always @(posedge clk)
  begin
    if (!nrst || !run)
    begin
      count <= `DIV_ZERO;
      tick <= 1'b0;
    end
    else if (count == `DIV_LAST)
    begin
      count <= `DIV_ZERO;
      tick <= 1'b1;
    end
    else
    begin
      count <= count + 4'h1;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* sar_output_drive.v */
/*
  Output driver for the parallel result bus, with byte swap and three-state enable.
  Assumes the latched result and a read-enable level from the controller.
*/
`timescale 1ns/1ns
`default_nettype none
`include "sar_adc_map.vh"
module sar_output_drive (
  // Clock and reset.
  input wire clk,
  input wire nrst,
  // Result and controls.
  input wire [15:0] result,
  input wire swap,
  input wire drive,
  // Bus pins.
  output reg [15:0] result_bus,
  output reg [15:0] result_bus_oe
);
  always @(posedge clk)
  begin
    if (!nrst)
    begin
      result_bus <= `CODE_ZERO;
      result_bus_oe <= `CODE_ZERO;
    end
    else
    begin
      if (swap)
        result_bus <= {result[`BYTE_BITS-1:0], result[`RES_BITS-1:`BYTE_BITS]};
      else
        result_bus <= result;
      result_bus_oe <= {`RES_BITS{drive}};
    end
  end
endmodule
`default_nettype wire

/* sar_adc_control.v */
/*
  Control of a 16-bit successive-approximation converter: start detection from the
  combined select and read/convert strobes, bit sequencing, result latching, status
  output and parallel bus drive.
  Assumes asynchronous strobe pins, a comparator input from the analog side (high
  means the trial code is at or below the held input), and a host that keeps its timing.
*/
`timescale 1ns/1ns
`default_nettype none
`include "sar_adc_map.vh"
module sar_adc_control (
  // Clock and reset.
  input wire clk,
  input wire nrst,
  // Host strobes, active low select.
  input wire select_n,
  input wire read_convert,
  input wire byte_swap,
  // Analog side.
  input wire comp_above,
  output reg hold,
  output reg [15:0] trial_code,
  // Status and bus.
  output reg busy_n,
  output wire [15:0] result_bus,
  output wire [15:0] result_bus_oe
);
  // Controller states.
  localparam IDLE = 2'b00;
  localparam CONVERT = 2'b01;
  localparam LOAD = 2'b10;
  localparam DONE = 2'b11;
  // Constant words: synchroniser idle levels and the first trial word.
  localparam [`PIN_COUNT-1:0] PIN_RESET = `PIN_IDLE;
  localparam [15:0] START_WORD = `CODE_NEG_MAX;

  // State and sequencing.
  reg [1:0] state;
  reg [1:0] next_state;
  reg [3:0] bit_idx;
  reg [3:0] next_bit_idx;
  // Pin synchronisers and the delayed copy used for edge detection.
  wire [`PIN_COUNT-1:0] pin_raw;
  reg [`PIN_COUNT-1:0] pin_m;
  reg [`PIN_COUNT-1:0] pin_s;
  reg [`PIN_COUNT-1:0] pin_d;
  wire sel_s;
  wire rc_s;
  wire swap_s;
  wire sel_d;
  wire rc_d;
  // Approximation word and output latches.
  reg [15:0] sar;
  reg [15:0] out_latch;
  wire [15:0] twos_word;
  // Control strobes and sequencing flags.
  reg drive;
  wire strobe_n;
  wire strobe_d_n;
  wire start_edge;
  wire tick;
  wire last_bit;
  wire running;
  wire load_now;

  // True when the slice at position pos is the one addressed by idx.
  function is_bit;
    input [4:0] idx;
    input [4:0] pos;
    begin
      is_bit = (idx == pos);
    end
  endfunction

  // Offset binary to two's complement: invert the sign bit, so midscale reads
  // zero, just below reads FFFF and the top of the range reads 7FFF.
  function [15:0] to_twos;
    input [15:0] word;
    begin
      to_twos = {~word[`RES_BITS-1], word[`RES_BITS-2:0]};
    end
  endfunction

  // The combined strobe is low only while both inputs sit at their active low level.
  function strobe_level;
    input sel_level;
    input rc_level;
    begin
      strobe_level = sel_level | rc_level;
    end
  endfunction

  assign pin_raw[`PIN_SEL] = select_n;
  assign pin_raw[`PIN_RC] = read_convert;
  assign pin_raw[`PIN_SWAP] = byte_swap;

  // Every pin passes two flip-flops before logic reads it; the third stage only
  // feeds the edge detector and resets to the idle level, so no false edge follows reset.
  genvar pi;
  generate
    for (pi = 0; pi < `PIN_COUNT; pi = pi + 1)
    begin : g_sync
      always @(posedge clk)
      begin
        if (!nrst)
        begin
          pin_m[pi] <= PIN_RESET[pi];
          pin_s[pi] <= PIN_RESET[pi];
          pin_d[pi] <= PIN_RESET[pi];
        end
        else
        begin
          pin_m[pi] <= pin_raw[pi];
          pin_s[pi] <= pin_m[pi];
          pin_d[pi] <= pin_s[pi];
        end
      end
    end
  endgenerate

  assign sel_s = pin_s[`PIN_SEL];
  assign rc_s = pin_s[`PIN_RC];
  assign swap_s = pin_s[`PIN_SWAP];
  assign sel_d = pin_d[`PIN_SEL];
  assign rc_d = pin_d[`PIN_RC];
  assign strobe_n = strobe_level(sel_s, rc_s);
  assign strobe_d_n = strobe_level(sel_d, rc_d);
  // A falling combined strobe covers both a read/convert fall under a low select and a
  // select fall under a low read/convert.
  assign start_edge = strobe_d_n & ~strobe_n;
  assign running = (state == CONVERT);
  assign last_bit = (bit_idx == `LSB_IDX);
  assign load_now = (state == LOAD);
  assign twos_word = to_twos(sar);

  // The divider only counts while converting, so every conversion starts on a full period.
  conv_clock_div u_div (
    .clk(clk),
    .nrst(nrst),
    .run(running),
    .tick(tick)
  );

  // Start edges are only looked at in IDLE; one arriving in CONVERT, LOAD or DONE is
  // dropped, so the host must keep a strobe high while the status rises.
  always @*
  begin
    next_state = state;
    case (state)
      IDLE:
      begin
        if (start_edge)
          next_state = CONVERT;
      end
      CONVERT:
      begin
        if (tick && last_bit)
          next_state = LOAD;
      end
      LOAD:
      begin
        next_state = DONE;
      end
      DONE:
      begin
        next_state = IDLE;
      end
      default:
      begin
        next_state = IDLE;
      end
    endcase
  end

  // The index starts at the MSB on every start and steps down once per conversion tick until it reaches the LSB.
  always @*
  begin
    next_bit_idx = bit_idx;
    case (state)
      IDLE:
      begin
        if (start_edge)
          next_bit_idx = `MSB_IDX;
      end
      CONVERT:
      begin
        if (tick && !last_bit)
          next_bit_idx = bit_idx - 4'h1;
      end
      default:
      begin
        next_bit_idx = bit_idx;
      end
    endcase
  end

  // Sequencing registers.
  always @(posedge clk)
  begin
    if (!nrst)
    begin
      state <= IDLE;
      bit_idx <= `MSB_IDX;
    end
    else
    begin
      state <= next_state;
      bit_idx <= next_bit_idx;
    end
  end

  // The sample-and-hold is held from the start edge until the word is latched.
  always @(posedge clk)
  begin
    if (!nrst)
      hold <= 1'b0;
    else
    begin
      case (state)
        IDLE:
        begin
          if (start_edge)
            hold <= 1'b1;
        end
        LOAD:
        begin
          hold <= 1'b0;
        end
        DONE:
        begin
          hold <= 1'b0;
        end
        default:
        begin
          hold <= hold;
        end
      endcase
    end
  end

  // Status falls with the start edge and rises one cycle after the latch takes the word.
  always @(posedge clk)
  begin
    if (!nrst)
      busy_n <= 1'b1;
    else
    begin
      case (state)
        IDLE:
        begin
          if (start_edge)
            busy_n <= 1'b0;
        end
        DONE:
        begin
          busy_n <= 1'b1;
        end
        default:
        begin
          busy_n <= busy_n;
        end
      endcase
    end
  end

  // The whole approximation word goes to the output latches in one step.
  always @(posedge clk)
  begin
    if (!nrst)
    begin
      out_latch <= `CODE_ZERO;
    end
    else if (load_now)
    begin
      out_latch <= twos_word;
    end
  end

  // One slice per result bit: cleared at the start, then decided when the index
  // reaches it, with the next lower trial bit raised in the same tick.
  genvar gi;
  generate
    for (gi = 0; gi < `RES_BITS; gi = gi + 1)
    begin : g_slice
      localparam [4:0] POS = gi;
      localparam [4:0] POS_UP = gi + 1;
      always @(posedge clk)
      begin
        if (!nrst)
        begin
          sar[gi] <= 1'b0;
          trial_code[gi] <= 1'b0;
        end
        else if (state == IDLE && start_edge)
        begin
          sar[gi] <= 1'b0;
          trial_code[gi] <= START_WORD[gi];
        end
        else if (running && tick)
        begin
          if (is_bit({1'b0, bit_idx}, POS))
          begin
            sar[gi] <= comp_above;
            trial_code[gi] <= comp_above;
          end
          else if (is_bit({1'b0, bit_idx}, POS_UP))
            trial_code[gi] <= 1'b1;
        end
      end
    end
  endgenerate

  // Drivers follow the strobe levels at all times, so a read while converting
  // shows the previous result.
  always @(posedge clk)
  begin
    if (!nrst)
    begin
      drive <= 1'b0;
    end
    else
    begin
      drive <= ~sel_s & rc_s;
    end
  end

  // Byte swap and three-state enable sit in the output stage.
  sar_output_drive u_out (
    .clk(clk),
    .nrst(nrst),
    .result(out_latch),
    .swap(swap_s),
    .drive(drive),
    .result_bus(result_bus),
    .result_bus_oe(result_bus_oe)
  );
endmodule
`default_nettype wire

/* sar_adc_monitor.sv */
/* Port checker for sar_adc_control.
   Assumes the 100 MHz clock and the synchronous active-low reset. */
`timescale 1ns/1ns
`default_nettype none
module sar_adc_monitor (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Strobes.
  input wire logic select_n,
  input wire logic read_convert,
  // Outputs.
  input wire logic hold,
  input wire logic [15:0] trial_code,
  input wire logic busy_n,
  input wire logic [15:0] result_bus_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence off_s;
    (select_n || !read_convert) [*6];
  endsequence
  sequence on_s;
    (!select_n && read_convert) [*6];
  endsequence
  sequence start_s;
    $fell(busy_n);
  endsequence
  AST_FLOAT: assert property (off_s |-> result_bus_oe == 16'h0000)
    else $error("bus not floating");
  AST_DRIVE: assert property (on_s |-> result_bus_oe == 16'hFFFF)
    else $error("bus not driven");
  AST_SAR_CLEAR: assert property (start_s |-> hold && trial_code == 16'h8000)
    else $error("bad conversion start");
  AST_NO_ABORT: assert property (start_s |-> !busy_n [*8])
    else $error("conversion cut short");
  AST_DONE: assert property (start_s |-> ##[200:300] busy_n)
    else $error("conversion too long");
  AST_HOLD_FIRST: assert property ($rose(busy_n) |-> !$past(hold))
    else $error("status rose before load");
  AST_IDLE: assert property (busy_n |-> !hold)
    else $error("hold while idle");
  AST_KICK: assert property ($fell(select_n || read_convert) && busy_n |-> ##[3:5] !busy_n)
    else $error("start not taken");
endmodule
bind sar_adc_control sar_adc_monitor mon_u (.clk(clk), .nrst(nrst), .select_n(select_n),
  .read_convert(read_convert), .hold(hold), .trial_code(trial_code), .busy_n(busy_n),
  .result_bus_oe(result_bus_oe));
`default_nettype wire

/* analog_side.sv */
/* Sample-and-hold and comparator model.
   Assumes the bench sets level as a two's complement input. */
`timescale 1ns/1ns
`default_nettype none
module analog_side (
  // Clock.
  input wire logic clk,
  // Converter side.
  input wire logic hold,
  input wire logic [15:0] trial_code,
  input wire logic [15:0] level,
  output logic comp_above
);
  logic [15:0] held;
  always @(posedge clk)
    if (!hold)
      held <= level;
  // Offset-binary trial word against the held input.
  assign comp_above = (held ^ 16'h8000) >= trial_code;
endmodule
`default_nettype wire

/* sar_adc_control_tb.sv */
/* Self-checking bench for sar_adc_control.
   Assumes analog_side as far side and the bound port checker. */
`timescale 1ns/1ns
`default_nettype none
module sar_adc_control_tb;
  logic clk, nrst, select_n, read_convert, byte_swap, comp_above, hold, busy_n;
  logic [15:0] trial_code, result_bus, result_bus_oe, level;
  logic [31:0] seed;
  int err_count, samples_checked;
  sar_adc_control dut_u (.clk(clk), .nrst(nrst), .select_n(select_n),
    .read_convert(read_convert), .byte_swap(byte_swap), .comp_above(comp_above),
    .hold(hold), .trial_code(trial_code), .busy_n(busy_n), .result_bus(result_bus),
    .result_bus_oe(result_bus_oe));
  analog_side model_u (.clk(clk), .hold(hold), .trial_code(trial_code), .level(level),
    .comp_above(comp_above));
  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function logic [15:0] bus_of(input logic [15:0] v, input logic sw);
    return sw ? {v[7:0], v[15:8]} : v;
  endfunction
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task give_verdict;
    $display("checked %0d bad %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task wait_busy(input logic v);
    for (int i = 0; i < 400 && busy_n !== v; i++)
      @(negedge clk);
    chk({15'h0000, busy_n}, {15'h0000, v});
  endtask
  // Mode high starts with select, mode low with read/convert; poke retries mid-run.
  task convert(input logic [15:0] v, input logic mode, input logic sw, input logic poke);
    level = v;
    byte_swap = sw;
    select_n = mode;
    read_convert = !mode;
    repeat (2) @(negedge clk);
    select_n = 1'h0;
    read_convert = 1'h0;
    repeat (5) @(negedge clk);
    select_n = mode;
    read_convert = 1'h1;
    wait_busy(1'h0);
    if (poke)
    begin
      read_convert = 1'h0;
      repeat (5) @(negedge clk);
      read_convert = 1'h1;
    end
    wait_busy(1'h1);
    select_n = 1'h0;
    repeat (6) @(negedge clk);
    chk(result_bus_oe, 16'hFFFF);
    chk(result_bus, bus_of(v, sw));
    select_n = 1'h1;
    repeat (6) @(negedge clk);
    chk(result_bus_oe, 16'h0000);
    repeat (150) @(negedge clk);
  endtask
  initial
  begin
    nrst = 1'h0;
    select_n = 1'h1;
    read_convert = 1'h1;
    byte_swap = 1'h0;
    level = 16'h0000;
    seed = 32'h1C18;
    err_count = 0;
    samples_checked = 0;
    repeat (20) @(negedge clk);
    nrst = 1'h1;
    repeat (3) @(negedge clk);
    convert(16'hFFFF, 1'h0, 1'h0, 1'h0);
    convert(16'h0000, 1'h1, 1'h1, 1'h0);
    convert(16'h7FFF, 1'h0, 1'h1, 1'h1);
    convert(16'h7FFE, 1'h1, 1'h0, 1'h0);
    convert(16'h8000, 1'h0, 1'h0, 1'h0);
    for (int k = 0; k < 8; k++)
    begin
      seed = lfsr(seed);
      convert(seed[15:0], seed[16], seed[17], seed[18] & ~seed[16]);
    end
    give_verdict;
  end
  initial
  begin
    #200000;
    err_count++;
    give_verdict;
  end
endmodule
`default_nettype wire
